// ===== tb/sps_bus_master.sv
`timescale 1ns/100ps
module sps_bus_master (
  // Resolved wire levels
  input wire logic scl_line,
  input wire logic sda_line,
  // High while pulling the wire low
  output logic scl_low,
  output logic sda_low
);
  // Both wires idle high; the clock stands still between frames
  initial begin
    scl_low = 1'b0;
    sda_low = 1'b0;
  end
  // Let the clock rise, but wait out any stretch by the slave
  task automatic clk_high();
    scl_low = 1'b0;
    wait (scl_line === 1'b1);
    #80;
  endtask
  task automatic start();
    sda_low = 1'b1;
    #80;
    scl_low = 1'b1;
    #40;
  endtask
  // Ack is sampled mid-high, since the slave may set it only on release
  task automatic send_byte(input logic [7:0] b, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      sda_low = ~b[i];
      #40;
      clk_high();
      scl_low = 1'b1;
      #40;
    end
    sda_low = 1'b0;
    #40;
    scl_low = 1'b0;
    wait (scl_line === 1'b1);
    #40;
    ack = ~sda_line;
    #40;
    scl_low = 1'b1;
    #80;
  endtask
  task automatic stop();
    sda_low = 1'b1;
    #40;
    clk_high();
    sda_low = 1'b0;
    #80;
  endtask
endmodule

// ===== tb/sps_rx_tb.sv
`timescale 1ns/100ps
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin failures++; \
  $display("[ERR] %s expected %h seen %h", n, e, g); end end
module sps_rx_tb;
  logic sys_clk, sys_rst, hsel, hwrite, hreadyout, hresp, irq, ack;
  logic scl_out, scl_oe, sda_out, sda_oe, m_scl_low, m_sda_low;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0] htrans;
  wire logic scl_line, sda_line;
  int failures, check_count;
  // Open-drain wires with pull-ups
  assign scl_line = ~(scl_oe & ~scl_out) & ~m_scl_low;
  assign sda_line = ~(sda_oe & ~sda_out) & ~m_sda_low;
  sps_rx dut (.sys_clk(sys_clk), .sys_rst(sys_rst), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .scl_in(scl_line),
    .scl_out(scl_out), .scl_oe(scl_oe), .sda_in(sda_line), .sda_out(sda_out),
    .sda_oe(sda_oe), .irq(irq));
  sps_bus_master m (.scl_line(scl_line), .sda_line(sda_line), .scl_low(m_scl_low),
    .sda_low(m_sda_low));
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  // Ready is read before the edge, where it cannot race the slave's update
  task automatic wait_rdy(output logic [31:0] d);
    logic r;
    do begin
      @(negedge sys_clk);
      r = hreadyout;
      d = hrdata;
      @(posedge sys_clk);
    end while (r !== 1'b1);
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd,
    output logic [31:0] rd);
    @(posedge sys_clk);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    wait_rdy(rd);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    wait_rdy(rd);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    bus(1'b1, a, d, x);
  endtask
  task automatic rd(input string n, input logic [7:0] a, input logic [31:0] e);
    logic [31:0] x;
    bus(1'b0, a, 32'h0, x);
    `CHK(n, e, x)
    `CHK("hresp", 1'b0, hresp)
  endtask
  // Software side of a held byte: inspect, clear, then release with an ack choice
  task automatic sw_hold(input logic [7:0] b, input logic [31:0] c);
    for (int i = 0; i < 500 && irq !== 1'b1; i++) @(posedge sys_clk);
    `CHK("scl_oe", 1'b1, scl_oe)
    rd("status", sps_pkg::REG_STAT, 32'hd);
    rd("buf", sps_pkg::REG_BUF, {24'h0, b});
    wr(sps_pkg::REG_ISTAT, 32'h1f);
    wr(sps_pkg::REG_CTRL, c);
  endtask
  task automatic final_report();
    if (failures == 0 && check_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    repeat (60000) @(posedge sys_clk);
    failures++;
    final_report();
  end
  initial begin
    sys_rst = 1'b1;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hwdata = 32'h0;
    failures = 0;
    check_count = 0;
    repeat (3) @(posedge sys_clk);
    sys_rst <= 1'b0;
    rd("ctrl", sps_pkg::REG_CTRL, {23'h0, sps_pkg::CTRL_RST});
    rd("events", sps_pkg::REG_ISTAT, 32'h0);
    rd("unmapped", 8'h18, 32'h0);
    wr(sps_pkg::REG_OWN, 32'h3a);
    wr(sps_pkg::REG_IMASK, 32'h1);
    wr(sps_pkg::REG_CTRL, 32'h185);
    m.start();
    rd("events", sps_pkg::REG_ISTAT, 32'h9);
    wr(sps_pkg::REG_BUF, 32'h55);
    rd("events", sps_pkg::REG_ISTAT, 32'hb);
    wr(sps_pkg::REG_ISTAT, 32'h1f);
    m.send_byte(8'h74, ack);
    `CHK("ack", 1'b1, ack)
    `CHK("irq", 1'b1, irq)
    rd("status", sps_pkg::REG_STAT, 32'h9);
    rd("buf", sps_pkg::REG_BUF, 32'h74);
    rd("status", sps_pkg::REG_STAT, 32'h8);
    wr(sps_pkg::REG_ISTAT, 32'h1f);
    `CHK("irq", 1'b0, irq)
    m.send_byte(8'ha5, ack);
    rd("events", sps_pkg::REG_ISTAT, 32'h1);
    m.send_byte(8'h3c, ack);
    `CHK("ack", 1'b0, ack)
    rd("events", sps_pkg::REG_ISTAT, 32'h5);
    rd("buf", sps_pkg::REG_BUF, 32'ha5);
    wr(sps_pkg::REG_ISTAT, 32'h1f);
    m.stop();
    rd("events", sps_pkg::REG_ISTAT, 32'h11);
    rd("status", sps_pkg::REG_STAT, 32'h0);
    wr(sps_pkg::REG_BUF, 32'h5a);
    rd("buf", sps_pkg::REG_BUF, 32'h5a);
    m.start();
    m.send_byte(8'h76, ack);
    `CHK("ack", 1'b0, ack)
    m.stop();
    wr(sps_pkg::REG_CTRL, 32'h187);
    m.start();
    m.send_byte(8'h74, ack);
    rd("buf", sps_pkg::REG_BUF, 32'h74);
    `CHK("scl_oe", 1'b1, scl_oe)
    wr(sps_pkg::REG_CTRL, 32'h187);
    `CHK("scl_oe", 1'b0, scl_oe)
    m.send_byte(8'h0f, ack);
    rd("status", sps_pkg::REG_STAT, 32'h9);
    wr(sps_pkg::REG_CTRL, 32'h1a7);
    m.send_byte(8'hc3, ack);
    `CHK("ack", 1'b1, ack)
    rd("buf", sps_pkg::REG_BUF, 32'hc3);
    `CHK("scl_oe", 1'b1, scl_oe)
    wr(sps_pkg::REG_CTRL, 32'h1d);
    m.stop();
    wr(sps_pkg::REG_ISTAT, 32'h1f);
    m.start();
    fork
      m.send_byte(8'h74, ack);
      sw_hold(8'h74, 32'h1d);
    join
    `CHK("ack", 1'b1, ack)
    rd("events", sps_pkg::REG_ISTAT, 32'h1);
    rd("status", sps_pkg::REG_STAT, 32'h8);
    wr(sps_pkg::REG_ISTAT, 32'h1f);
    fork
      m.send_byte(8'h99, ack);
      sw_hold(8'h99, 32'h5d);
    join
    `CHK("ack", 1'b0, ack)
    rd("events", sps_pkg::REG_ISTAT, 32'h0);
    wr(sps_pkg::REG_CTRL, 32'h1d);
    m.stop();
    rd("events", sps_pkg::REG_ISTAT, 32'h10);
    `CHK("irq", 1'b0, irq)
    wr(sps_pkg::REG_CTRL, 32'h1f);
    wr(sps_pkg::REG_ISTAT, 32'h1f);
    m.start();
    fork
      m.send_byte(8'h74, ack);
      sw_hold(8'h74, 32'h1f);
    join
    rd("events", sps_pkg::REG_ISTAT, 32'h1);
    `CHK("scl_oe", 1'b1, scl_oe)
    wr(sps_pkg::REG_CTRL, 32'h1f);
    m.stop();
    final_report();
  end
endmodule

// ===== verilog/sps_pkg.sv
package sps_pkg;
  // Register byte offsets
  localparam logic [7:0] REG_BUF = 8'h00;
  localparam logic [7:0] REG_STAT = 8'h04;
  localparam logic [7:0] REG_CTRL = 8'h08;
  localparam logic [7:0] REG_OWN = 8'h0c;
  localparam logic [7:0] REG_ISTAT = 8'h10;
  localparam logic [7:0] REG_IMASK = 8'h14;
  // Status register fields
  localparam int ST_FULL = 0;
  localparam int ST_RW = 1;
  localparam int ST_ACKT = 2;
  localparam int ST_BUSY = 3;
  // Control register fields
  localparam int CT_EN = 0;
  localparam int CT_STRETCH = 1;
  localparam int CT_RELEASE = 2;
  localparam int CT_AHOLD = 3;
  localparam int CT_DHOLD = 4;
  localparam int CT_OVWR = 5;
  localparam int CT_ACKVAL = 6;
  localparam int CT_STARTIE = 7;
  localparam int CT_STOPIE = 8;
  localparam int CTRL_W = 9;
  localparam logic [8:0] CTRL_RST = 9'h004;
  // Event status fields, write one to clear
  localparam int EV_IRQ = 0;
  localparam int EV_COLL = 1;
  localparam int EV_OVF = 2;
  localparam int EV_START = 3;
  localparam int EV_STOP = 4;
  localparam int EV_W = 5;
  localparam logic [4:0] EV_RST = 5'h00;
  localparam logic [4:0] MASK_RST = 5'h00;
  // Own address reset value
  localparam logic [6:0] OWN_RST = 7'h00;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  // Receive sequencer, Gray coded along idle, shift, ack
  typedef enum logic [1:0] {
    SPS_IDLE = 2'b00,
    SPS_SHIFT = 2'b01,
    SPS_ACK = 2'b11,
    SPS_WAIT = 2'b10
  } sps_state_t;
endpackage

// ===== verilog/sps_rx.sv
// Added by the designer: the AHB-Lite slave port and the placing of the registers.
`timescale 1ns/100ps
module sps_rx (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic sys_rst,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // Two-wire bus pins
  input wire logic scl_in,
  output logic scl_out,
  output logic scl_oe,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  // Interrupt
  output logic irq
);
  sps_pkg::sps_state_t state_ff;
  logic scl_s, sda_s, scl_d_ff, sda_d_ff;
  logic [7:0] shift_ff, serial_buffer_ff;
  logic [3:0] cnt_ff;
  logic is_addr_ff, ack_low_ff, hold_wait_ff, scl_hold_ff;
  logic buffer_full_ff, rw_ind_ff, ack_time_ff;
  logic [sps_pkg::CTRL_W-1:0] ctrl_ff;
  logic [6:0] own_ff;
  logic [sps_pkg::EV_W-1:0] ev_ff, mask_ff, ev_set;
  logic [7:0] addr_ff;
  logic wr_ff, dph_ff, rdy_ff;
  logic [31:0] rdata_ff;
  logic scl_rise, scl_fall, start_det, stop_det;
  logic byte_done, ack_done, hold_mode, addr_match, overflow, accept, load;
  logic hold_hit;
  logic bus_wr, rd_buf, buf_wr, ctl_wr, busy, hw_release_clr;

  // Two flops on the pins before any logic sees them
  sps_sync #(.W(2)) u_sync (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .async_in({scl_in, sda_in}),
    .sync_out({scl_s, sda_s})
  );

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      scl_d_ff <= 1'b1;
      sda_d_ff <= 1'b1;
    end else begin
      scl_d_ff <= scl_s;
      sda_d_ff <= sda_s;
    end
  end

  assign scl_rise = scl_s & ~scl_d_ff;
  assign scl_fall = ~scl_s & scl_d_ff;
  assign start_det = ctrl_ff[sps_pkg::CT_EN] & scl_s & scl_d_ff & sda_d_ff & ~sda_s;
  assign stop_det = ctrl_ff[sps_pkg::CT_EN] & scl_s & scl_d_ff & ~sda_d_ff & sda_s;

  assign byte_done = (state_ff == sps_pkg::SPS_SHIFT) && scl_fall
    && (cnt_ff == sps_pkg::BITS_PER_BYTE);
  assign ack_done = (state_ff == sps_pkg::SPS_ACK) && scl_fall && !hold_wait_ff;
  assign hold_mode = is_addr_ff ? ctrl_ff[sps_pkg::CT_AHOLD] : ctrl_ff[sps_pkg::CT_DHOLD];
  assign addr_match = (shift_ff[7:1] == own_ff) && !shift_ff[0];
  assign overflow = buffer_full_ff | ev_ff[sps_pkg::EV_OVF];
  assign accept = (!overflow || ctrl_ff[sps_pkg::CT_OVWR])
    && (addr_match || !is_addr_ff);
  assign load = byte_done && accept;
  // Only a matching address or a data byte may hold the bus
  assign hold_hit = byte_done && hold_mode && (addr_match || !is_addr_ff);
  assign busy = state_ff != sps_pkg::SPS_IDLE;

  // Receive sequencer
  always_ff @(posedge sys_clk) begin
    if (sys_rst || !ctrl_ff[sps_pkg::CT_EN]) begin
      state_ff <= sps_pkg::SPS_IDLE;
      cnt_ff <= 4'h0;
      is_addr_ff <= 1'b0;
    end else if (stop_det) begin
      state_ff <= sps_pkg::SPS_IDLE;
    end else if (start_det) begin
      state_ff <= sps_pkg::SPS_SHIFT;
      cnt_ff <= 4'h0;
      is_addr_ff <= 1'b1;
    end else begin
      unique case (state_ff)
        sps_pkg::SPS_SHIFT: begin
          if (scl_rise && cnt_ff != sps_pkg::BITS_PER_BYTE) begin
            cnt_ff <= cnt_ff + 4'h1;
          end else if (byte_done) begin
            // Foreign address: sit out until next start or stop
            if (is_addr_ff && !addr_match) begin
              state_ff <= sps_pkg::SPS_WAIT;
            end else begin
              state_ff <= sps_pkg::SPS_ACK;
            end
          end
        end
        sps_pkg::SPS_ACK: begin
          if (ack_done) begin
            cnt_ff <= 4'h0;
            is_addr_ff <= 1'b0;
            state_ff <= ack_low_ff ? sps_pkg::SPS_SHIFT : sps_pkg::SPS_WAIT;
          end
        end
        sps_pkg::SPS_IDLE, sps_pkg::SPS_WAIT: begin
        end
      endcase
    end
  end

  // Serial data in, most significant bit first
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      shift_ff <= 8'h00;
    end else if (state_ff == sps_pkg::SPS_SHIFT && scl_rise) begin
      shift_ff <= {shift_ff[6:0], sda_s};
    end
  end

  // Acknowledge decision and release wait
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      ack_low_ff <= 1'b0;
      hold_wait_ff <= 1'b0;
    end else if (byte_done) begin
      hold_wait_ff <= hold_hit;
      ack_low_ff <= !hold_mode && accept;
    end else if (hold_wait_ff && ctrl_ff[sps_pkg::CT_RELEASE]) begin
      hold_wait_ff <= 1'b0;
      ack_low_ff <= !ctrl_ff[sps_pkg::CT_ACKVAL];
    end else if (ack_done || start_det || stop_det) begin
      ack_low_ff <= 1'b0;
      hold_wait_ff <= 1'b0;
    end
  end

  // Clock stays held one cycle past the release, so the ack level leads the rising clock
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      scl_hold_ff <= 1'b0;
    end else begin
      scl_hold_ff <= hold_wait_ff;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      ack_time_ff <= 1'b0;
    end else if (hold_hit) begin
      ack_time_ff <= 1'b1;
    end else if (ack_done || stop_det) begin
      ack_time_ff <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      rw_ind_ff <= 1'b0;
    end else if (byte_done && is_addr_ff && shift_ff[7:1] == own_ff) begin
      // Own address with the read bit is refused but still reported
      rw_ind_ff <= shift_ff[0];
    end
  end

  // Bus side
  assign bus_wr = dph_ff & wr_ff;
  assign rd_buf = dph_ff & ~wr_ff & (addr_ff == sps_pkg::REG_BUF);
  assign buf_wr = bus_wr & (addr_ff == sps_pkg::REG_BUF);
  assign ctl_wr = bus_wr & (addr_ff == sps_pkg::REG_CTRL);

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      dph_ff <= 1'b0;
      rdy_ff <= 1'b1;
      wr_ff <= 1'b0;
      addr_ff <= 8'h00;
    end else if (hsel && htrans[1] && hready) begin
      dph_ff <= 1'b1;
      rdy_ff <= 1'b0;
      wr_ff <= hwrite;
      addr_ff <= haddr[7:0];
    end else begin
      dph_ff <= 1'b0;
      rdy_ff <= 1'b1;
    end
  end

  // Received byte wins over a colliding bus write
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      serial_buffer_ff <= 8'h00;
    end else if (load) begin
      serial_buffer_ff <= shift_ff;
    end else if (buf_wr && !busy && !ev_ff[sps_pkg::EV_COLL]) begin
      serial_buffer_ff <= hwdata[7:0];
    end
  end

  // Set wins over a read in the same cycle
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      buffer_full_ff <= 1'b0;
    end else begin
      buffer_full_ff <= load | (buffer_full_ff & ~rd_buf);
    end
  end

  // Hardware clears the release bit; a same-cycle software write wins
  assign hw_release_clr = hold_hit
    || (ack_done && ack_low_ff && ctrl_ff[sps_pkg::CT_STRETCH]);

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      ctrl_ff <= sps_pkg::CTRL_RST;
      own_ff <= sps_pkg::OWN_RST;
      mask_ff <= sps_pkg::MASK_RST;
    end else begin
      if (ctl_wr) begin
        ctrl_ff <= hwdata[sps_pkg::CTRL_W-1:0];
      end else if (hw_release_clr) begin
        ctrl_ff[sps_pkg::CT_RELEASE] <= 1'b0;
      end
      if (bus_wr && addr_ff == sps_pkg::REG_OWN) begin
        own_ff <= hwdata[6:0];
      end
      if (bus_wr && addr_ff == sps_pkg::REG_IMASK) begin
        mask_ff <= hwdata[sps_pkg::EV_W-1:0];
      end
    end
  end

  always_comb begin
    ev_set = '0;
    ev_set[sps_pkg::EV_IRQ] = (load && !hold_mode)
      || hold_hit
      || (ack_done && ack_low_ff && hold_mode)
      || (start_det && ctrl_ff[sps_pkg::CT_STARTIE])
      || (stop_det && ctrl_ff[sps_pkg::CT_STOPIE]);
    ev_set[sps_pkg::EV_COLL] = buf_wr && (busy || ev_ff[sps_pkg::EV_COLL]);
    ev_set[sps_pkg::EV_OVF] = byte_done && overflow && !ctrl_ff[sps_pkg::CT_OVWR]
      && (addr_match || !is_addr_ff);
    ev_set[sps_pkg::EV_START] = start_det;
    ev_set[sps_pkg::EV_STOP] = stop_det;
  end

  // Sticky events: set wins over write-one-to-clear
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      ev_ff <= sps_pkg::EV_RST;
    end else if (bus_wr && addr_ff == sps_pkg::REG_ISTAT) begin
      ev_ff <= (ev_ff & ~hwdata[sps_pkg::EV_W-1:0]) | ev_set;
    end else begin
      ev_ff <= ev_ff | ev_set;
    end
  end

  // The shift register has no address of its own
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      rdata_ff <= 32'h0000_0000;
    end else if (dph_ff && !wr_ff) begin
      unique case (addr_ff)
        sps_pkg::REG_BUF: rdata_ff <= {24'h000000, serial_buffer_ff};
        sps_pkg::REG_STAT: rdata_ff <= {28'h0000000, busy, ack_time_ff, rw_ind_ff,
          buffer_full_ff};
        sps_pkg::REG_CTRL: rdata_ff <= {23'h000000, ctrl_ff};
        sps_pkg::REG_OWN: rdata_ff <= {25'h0000000, own_ff};
        sps_pkg::REG_ISTAT: rdata_ff <= {27'h0000000, ev_ff};
        sps_pkg::REG_IMASK: rdata_ff <= {27'h0000000, mask_ff};
        default: rdata_ff <= 32'h0000_0000;
      endcase
    end
  end

  assign hrdata = rdata_ff;
  assign hreadyout = rdy_ff;
  assign hresp = 1'b0;
  assign irq = |(ev_ff & mask_ff);

  // Open drain: only ever pull low; relies on the master waiting
  assign scl_out = 1'b0;
  assign scl_oe = !ctrl_ff[sps_pkg::CT_RELEASE]
    || hold_wait_ff || scl_hold_ff;
  assign sda_out = 1'b0;
  assign sda_oe = (state_ff == sps_pkg::SPS_ACK) && ack_low_ff && !hold_wait_ff;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);

  sequence s_basic_accept;
    byte_done && accept && !hold_mode;
  endsequence

  sequence s_hold_byte;
    byte_done && hold_mode && (addr_match || !is_addr_ff);
  endsequence

  a_byte_load: assert property (s_basic_accept |=> buffer_full_ff && ev_ff[0]
    && serial_buffer_ff == $past(shift_ff))
    else $error("received byte not moved to buffer");
  a_write_coll: assert property (buf_wr && busy |=> ev_ff[1])
    else $error("busy buffer write did not flag collision");
  a_read_clear: assert property (rd_buf && !load |=> !buffer_full_ff)
    else $error("buffer read left full flag set");
  a_addr_nack: assert property (byte_done && (addr_match || !is_addr_ff) && overflow
    && !ctrl_ff[sps_pkg::CT_OVWR] && !hold_mode && !rd_buf |=> !sda_oe
    && ev_ff[sps_pkg::EV_OVF] && buffer_full_ff == $past(buffer_full_ff)
    && $stable(serial_buffer_ff))
    else $error("overflowed byte was acknowledged");
  a_ack_drive: assert property (s_basic_accept |=> sda_oe throughout !scl_fall[*2])
    else $error("acknowledge not driven after accepted byte");
  a_stretch_hold: assert property (ack_done && ack_low_ff && ctrl_ff[1] && !ctl_wr
    |=> scl_oe)
    else $error("clock not stretched after byte");
  a_start_flag: assert property (start_det
    |=> ev_ff[sps_pkg::EV_START] && state_ff == sps_pkg::SPS_SHIFT)
    else $error("start not recorded");
  a_stop_idle: assert property (stop_det |=> ev_ff[4] && state_ff == sps_pkg::SPS_IDLE)
    else $error("stop did not idle the bus");
  a_hold_irq: assert property ((s_hold_byte and !ctl_wr) |=> scl_oe && ev_ff[0]
    && ack_time_ff && !sda_oe)
    else $error("hold mode byte not stretched with interrupt");
  a_foreign_quiet: assert property (byte_done && is_addr_ff && !addr_match
    |=> state_ff == sps_pkg::SPS_WAIT && !hold_wait_ff && !sda_oe)
    else $error("foreign address was held or acknowledged");
  a_ack_setup: assert property ($fell(hold_wait_ff) && ack_low_ff
    && state_ff == sps_pkg::SPS_ACK |-> sda_oe && scl_oe)
    else $error("clock released before acknowledge was driven");
endmodule

// ===== verilog/sps_sync.sv
`timescale 1ns/100ps
module sps_sync #(
  parameter int W = 2
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic sys_rst,
  // Levels
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);
  initial begin
    if (W < 1) $error("sps_sync: width must be at least one");
  end

  logic [W-1:0] meta_ff;
  logic [W-1:0] sync_ff;

  // Idle bus level is high on both wires
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      meta_ff <= '1;
      sync_ff <= '1;
    end else begin
      meta_ff <= async_in;
      sync_ff <= meta_ff;
    end
  end

  assign sync_out = sync_ff;
endmodule
